// ===== inc/acr_defines.vh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          amplifier core control register group.
// Assumes: 8-bit registers on a byte-addressed control port.
// Notes:   Definitions only.
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ACR_OFS_CORE_RESET_REQUEST   8'h01
`define ACR_OFS_OUTPUT_STAGE_CONFIG  8'h02
`define ACR_OFS_POWER_STATE_AND_MUTE 8'h03
`define ACR_OFS_PAGE_WRAP_CONTROL    8'h0f

// ****************************************************************
// Reset values
// ****************************************************************
`define ACR_RST_CORE_RESET_REQUEST   8'h00
`define ACR_RST_OUTPUT_STAGE_CONFIG  8'h00
`define ACR_RST_POWER_STATE_AND_MUTE 8'h10
`define ACR_RST_PAGE_WRAP_CONTROL    8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define ACR_BIT_FULL_CORE_RESET      4
`define ACR_BIT_REG_RESET            0
`define ACR_FREQ_MSB                 6
`define ACR_FREQ_LSB                 4
`define ACR_BIT_PARALLEL_BRIDGE      2
`define ACR_MOD_MSB                  1
`define ACR_MOD_LSB                  0
`define ACR_BIT_DSP_HOLD             4
`define ACR_BIT_MUTE                 3
`define ACR_PWR_MSB                  1
`define ACR_PWR_LSB                  0
`define ACR_BIT_PAGE_WRAP_DISABLE    3

// ****************************************************************
// Writable bit masks (reserved-but-R/W bits stored, read-only zero)
// ****************************************************************
`define ACR_MASK_CORE_RESET_REQUEST  8'he0
`define ACR_MASK_OUTPUT_STAGE_CONFIG 8'hff
`define ACR_MASK_POWER_STATE_AND_MUTE 8'hff
`define ACR_MASK_PAGE_WRAP_CONTROL   8'hff

// ****************************************************************
// Switching frequency codes
// ****************************************************************
`define ACR_FREQ_768K                3'h0
`define ACR_FREQ_384K                3'h1
`define ACR_FREQ_480K                3'h3
`define ACR_FREQ_576K                3'h4

// ****************************************************************
// Modulation codes
// ****************************************************************
`define ACR_MOD_BD_MODULATION        2'h0
`define ACR_MOD_ONE_SIDE_PWM         2'h1
`define ACR_MOD_HYBRID               2'h2

// ****************************************************************
// Power state codes
// ****************************************************************
`define ACR_PWR_DEEP_SLEEP           2'h0
`define ACR_PWR_SLEEP                2'h1
`define ACR_PWR_HIZ                  2'h2
`define ACR_PWR_PLAY                 2'h3

// ****************************************************************
// Paging
// ****************************************************************
`define ACR_PAGE_WRAP_START          8'h08
`define ACR_PAGE_LAST                8'h7f

// ****************************************************************
// Timing
// ****************************************************************
`define ACR_CLK_PERIOD_NS            8
`define ACR_CORE_RESET_NS            64
`define ACR_CORE_RESET_CYCLES        ((`ACR_CORE_RESET_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)
`define ACR_VOL_STEP_NS              1000
`define ACR_VOL_STEP_CYCLES          (`ACR_VOL_STEP_NS / `ACR_CLK_PERIOD_NS)
`define ACR_VOL_FULL                 8'hff

`endif

// ===== rtl/acr_volume_ramp.v
// Purpose: Soft volume ramp between full scale and silence.
// Assumes: One step per step_cycles clocks.
// Notes:   Level moves one code at a time, except that soft_reset clears it to zero at once.
`timescale 1ns/10ps
`default_nettype none

module acr_volume_ramp #(
  parameter STEP_CYCLES = 125,
  parameter FULL        = 8'hff
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       soft_reset,
  input  wire       mute,
  output reg  [7:0] level,
  output wire       ramping
);

  reg [15:0] step_count;
  wire [7:0] target;
  wire       step_due;

  assign target   = mute ? 8'h00 : FULL[7:0];
  assign ramping  = (level != target);
  assign step_due = (step_count == STEP_CYCLES[15:0] - 16'h0001);

  // ****************************************************************
  // Ramp: stepping avoids pop and click on mute changes
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      step_count <= 16'h0000;
      level      <= 8'h00;
    end else if (soft_reset) begin
      step_count <= 16'h0000;
      level      <= 8'h00;
    end else if (!ramping) begin
      step_count <= 16'h0000;
    end else if (step_due) begin
      step_count <= 16'h0000;
      if (level < target) begin
        level <= level + 8'h01;
      end else begin
        level <= level - 8'h01;
      end
    end else begin
      step_count <= step_count + 16'h0001;
    end
  end

endmodule // acr_volume_ramp

`default_nettype wire

// ===== rtl/acr_core_regs.v
// Purpose: Control-port register group of a class-D amplifier core: resets,
//          switching frequency, output stage, modulation, DSP hold, soft mute,
//          power state and page wrap for auto-incrementing access.
// Assumes: Byte-wide register port with a single-cycle write or read strobe on
//          clk; page address logic outside queries the wrap here.
// Notes:   Reserved bits of read/write fields are stored and read back.
`timescale 1ns/10ps
`include "acr_defines.vh"
`default_nettype none

module acr_core_regs #(
  parameter CORE_RESET_CYCLES = `ACR_CORE_RESET_CYCLES,
  parameter VOL_STEP_CYCLES   = `ACR_VOL_STEP_CYCLES
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       reg_write,
  input  wire       reg_read,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       page_incr,
  input  wire [7:0] cur_book,
  input  wire [7:0] cur_page,
  input  wire [7:0] cur_addr,
  output reg  [7:0] next_page,
  output reg  [7:0] next_addr,
  output wire       core_reset,
  output wire       coef_ram_clear,
  output reg  [2:0] switching_frequency_select,
  output reg  [9:0] switching_frequency_khz,
  output reg        freq_reserved,
  output reg        parallel_bridge_select,
  output reg  [1:0] modulation_scheme_select,
  output reg        dsp_hold_in_reset,
  output reg        dsp_running,
  output reg        mute_request,
  output wire [7:0] volume_level,
  output wire       volume_ramping,
  output reg  [1:0] power_state,
  output reg        state_deep_sleep,
  output reg        state_sleep,
  output reg        state_hiz,
  output reg        state_play,
  output reg        page_wrap_disable
);

  // ****************************************************************
  // Core reset sequencer states
  // ****************************************************************
  localparam ST_IDLE  = 2'b01;
  localparam ST_RESET = 2'b10;

  // Reset values sliced per field, so no default is cut by width
  localparam [7:0] RST_REQ   = `ACR_RST_CORE_RESET_REQUEST;
  localparam [7:0] RST_STAGE = `ACR_RST_OUTPUT_STAGE_CONFIG;
  localparam [7:0] RST_CTRL  = `ACR_RST_POWER_STATE_AND_MUTE;
  localparam [7:0] RST_WRAP  = `ACR_RST_PAGE_WRAP_CONTROL;

  reg  [1:0]  seq_state;
  reg  [1:0]  next_seq_state;
  reg  [15:0] seq_count;
  // Reserved bits, kept for read-back
  reg  [2:0]  reg0_reserved;
  reg         output_rsv7;
  reg         output_rsv3;
  reg  [2:0]  ctrl2_rsv;
  reg         ctrl2_rsv2;
  reg  [3:0]  wrap_rsv_hi;
  reg  [2:0]  wrap_rsv_lo;
  wire        wr_reset_reg;
  wire        full_reset_req;
  wire        reg_reset_req;
  wire        soft_clear;

  assign wr_reset_reg   = reg_write && (reg_addr == `ACR_OFS_CORE_RESET_REQUEST);
  assign full_reset_req = wr_reset_reg && reg_wdata[`ACR_BIT_FULL_CORE_RESET];
  assign reg_reset_req  = wr_reset_reg && reg_wdata[`ACR_BIT_REG_RESET];
  assign core_reset     = (seq_state == ST_RESET);
  assign coef_ram_clear = core_reset;
  // Register-only reset never touches RAM
  assign soft_clear     = full_reset_req || reg_reset_req || core_reset;

  // ****************************************************************
  // Full core reset pulse stretcher
  // ****************************************************************
  always @* begin
    next_seq_state = seq_state;
    case (seq_state)
      ST_IDLE: begin
        if (full_reset_req) begin
          next_seq_state = ST_RESET;
        end
      end
      ST_RESET: begin
        if (seq_count == CORE_RESET_CYCLES[15:0] - 16'h0001) begin
          next_seq_state = ST_IDLE;
        end
      end
      default: begin
        // Illegal code falls back to idle
        next_seq_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_state <= ST_IDLE;
      seq_count <= 16'h0000;
    end else begin
      seq_state <= next_seq_state;
      // Count runs only while the stretch is active
      if (seq_state == ST_RESET) begin
        seq_count <= seq_count + 16'h0001;
      end else begin
        seq_count <= 16'h0000;
      end
    end
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg0_reserved              <= 3'h0;
      output_rsv7                <= 1'b0;
      switching_frequency_select <= `ACR_FREQ_768K;
      output_rsv3                <= 1'b0;
      parallel_bridge_select     <= 1'b0;
      modulation_scheme_select   <= `ACR_MOD_BD_MODULATION;
      ctrl2_rsv                  <= 3'h0;
      dsp_hold_in_reset          <= 1'b1;
      mute_request               <= 1'b0;
      ctrl2_rsv2                 <= 1'b0;
      power_state                <= `ACR_PWR_DEEP_SLEEP;
      wrap_rsv_hi                <= 4'h0;
      page_wrap_disable          <= 1'b0;
      wrap_rsv_lo                <= 3'h0;
    end else if (soft_clear) begin
      // Defaults from the reset constants
      reg0_reserved              <= RST_REQ[7:5];
      output_rsv7                <= RST_STAGE[7];
      switching_frequency_select <= RST_STAGE[`ACR_FREQ_MSB:`ACR_FREQ_LSB];
      output_rsv3                <= RST_STAGE[3];
      parallel_bridge_select     <= RST_STAGE[`ACR_BIT_PARALLEL_BRIDGE];
      modulation_scheme_select   <= RST_STAGE[`ACR_MOD_MSB:`ACR_MOD_LSB];
      ctrl2_rsv                  <= RST_CTRL[7:5];
      dsp_hold_in_reset          <= RST_CTRL[`ACR_BIT_DSP_HOLD];
      mute_request               <= RST_CTRL[`ACR_BIT_MUTE];
      ctrl2_rsv2                 <= RST_CTRL[2];
      power_state                <= RST_CTRL[`ACR_PWR_MSB:`ACR_PWR_LSB];
      wrap_rsv_hi                <= RST_WRAP[7:4];
      page_wrap_disable          <= RST_WRAP[`ACR_BIT_PAGE_WRAP_DISABLE];
      wrap_rsv_lo                <= RST_WRAP[2:0];
    end else if (reg_write) begin
      case (reg_addr)
        `ACR_OFS_CORE_RESET_REQUEST: begin
          // Request bits are never stored
          reg0_reserved <= reg_wdata[7:5];
        end
        `ACR_OFS_OUTPUT_STAGE_CONFIG: begin
          output_rsv7                <= reg_wdata[7];
          switching_frequency_select <= reg_wdata[`ACR_FREQ_MSB:`ACR_FREQ_LSB];
          output_rsv3                <= reg_wdata[3];
          parallel_bridge_select     <= reg_wdata[`ACR_BIT_PARALLEL_BRIDGE];
          modulation_scheme_select   <= reg_wdata[`ACR_MOD_MSB:`ACR_MOD_LSB];
        end
        `ACR_OFS_POWER_STATE_AND_MUTE: begin
          ctrl2_rsv         <= reg_wdata[7:5];
          // Host must wait for clocks to settle before clearing
          dsp_hold_in_reset <= reg_wdata[`ACR_BIT_DSP_HOLD];
          mute_request      <= reg_wdata[`ACR_BIT_MUTE];
          ctrl2_rsv2        <= reg_wdata[2];
          power_state       <= reg_wdata[`ACR_PWR_MSB:`ACR_PWR_LSB];
        end
        `ACR_OFS_PAGE_WRAP_CONTROL: begin
          wrap_rsv_hi       <= reg_wdata[7:4];
          page_wrap_disable <= reg_wdata[`ACR_BIT_PAGE_WRAP_DISABLE];
          wrap_rsv_lo       <= reg_wdata[2:0];
        end
        default: begin
          // Unmapped offsets are ignored
          reg0_reserved <= reg0_reserved;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `ACR_OFS_CORE_RESET_REQUEST: begin
          reg_rdata <= {reg0_reserved, 5'h00};
        end
        `ACR_OFS_OUTPUT_STAGE_CONFIG: begin
          reg_rdata <= {output_rsv7, switching_frequency_select, output_rsv3,
                        parallel_bridge_select, modulation_scheme_select};
        end
        `ACR_OFS_POWER_STATE_AND_MUTE: begin
          reg_rdata <= {ctrl2_rsv, dsp_hold_in_reset, mute_request, ctrl2_rsv2, power_state};
        end
        `ACR_OFS_PAGE_WRAP_CONTROL: begin
          reg_rdata <= {wrap_rsv_hi, page_wrap_disable, wrap_rsv_lo};
        end
        default: begin
          // Unmapped offsets read zero
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Decoded controls
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      switching_frequency_khz <= 10'h000;
      freq_reserved           <= 1'b0;
      dsp_running             <= 1'b0;
      state_deep_sleep        <= 1'b0;
      state_sleep             <= 1'b0;
      state_hiz               <= 1'b0;
      state_play              <= 1'b0;
    end else begin
      freq_reserved <= 1'b0;
      case (switching_frequency_select)
        `ACR_FREQ_768K: begin
          switching_frequency_khz <= 10'h300;
        end
        `ACR_FREQ_384K: begin
          switching_frequency_khz <= 10'h180;
        end
        `ACR_FREQ_480K: begin
          switching_frequency_khz <= 10'h1e0;
        end
        `ACR_FREQ_576K: begin
          switching_frequency_khz <= 10'h240;
        end
        default: begin
          // Reserved code keeps the last valid frequency
          freq_reserved <= 1'b1;
        end
      endcase
      dsp_running      <= !dsp_hold_in_reset && !core_reset;
      // Registered one-hot decode of the power state
      state_deep_sleep <= (power_state == `ACR_PWR_DEEP_SLEEP);
      state_sleep      <= (power_state == `ACR_PWR_SLEEP);
      state_hiz        <= (power_state == `ACR_PWR_HIZ);
      state_play       <= (power_state == `ACR_PWR_PLAY);
    end
  end

  // ****************************************************************
  // Page auto-increment wrap
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      next_page <= 8'h00;
      next_addr <= 8'h00;
    end else if (page_incr) begin
      next_page <= cur_page;
      next_addr <= cur_addr + 8'h01;
      // Book zero always counts straight on
      if ((cur_book != 8'h00) && (cur_addr == `ACR_PAGE_LAST)) begin
        if (page_wrap_disable) begin
          next_addr <= 8'h00;
        end else begin
          next_page <= cur_page + 8'h01;
          next_addr <= `ACR_PAGE_WRAP_START;
        end
      end
    end
  end

  // ****************************************************************
  // Soft mute volume ramp
  // ****************************************************************
  acr_volume_ramp #(
    .STEP_CYCLES (VOL_STEP_CYCLES),
    .FULL        (`ACR_VOL_FULL)
  ) u_ramp (
    .clk        (clk),
    .rst        (rst),
    .soft_reset (core_reset),
    // A held DSP sends nothing, so ramp down as well
    .mute       (mute_request || dsp_hold_in_reset),
    .level      (volume_level),
    .ramping    (volume_ramping)
  );

endmodule // acr_core_regs

`default_nettype wire

// ===== tb/acr_core_regs_properties.sv
// Purpose: Concurrent checks on the amplifier core control registers.
// Assumes: Bound to acr_core_regs; one clock, async active-high reset.
// Notes:   Core-reset span written as 8, the default count.
`timescale 1ns/10ps
`default_nettype none

module acr_core_regs_chk #(
  parameter CORE_RESET_CYCLES = 8,
  parameter VOL_STEP_CYCLES   = 2
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       page_incr,
  input wire logic [7:0] cur_book,
  input wire logic [7:0] cur_page,
  input wire logic [7:0] cur_addr,
  input wire logic [7:0] next_page,
  input wire logic [7:0] next_addr,
  input wire logic       core_reset,
  input wire logic       coef_ram_clear,
  input wire logic [2:0] switching_frequency_select,
  input wire logic [9:0] switching_frequency_khz,
  input wire logic       freq_reserved,
  input wire logic       parallel_bridge_select,
  input wire logic [1:0] modulation_scheme_select,
  input wire logic       dsp_hold_in_reset,
  input wire logic       dsp_running,
  input wire logic       mute_request,
  input wire logic [7:0] volume_level,
  input wire logic [1:0] power_state,
  input wire logic       state_hiz,
  input wire logic       state_play,
  input wire logic       page_wrap_disable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  wire logic  w01 = reg_write && reg_addr == 8'h01 && !core_reset;
  wire logic  wrap = page_incr && cur_book != 8'h00 && cur_addr == 8'h7f;
  logic [7:0] wdata_q;

  // Write data one cycle back, for field checks
  always_ff @(posedge clk) begin
    wdata_q <= reg_wdata;
  end

  AST_CORE_RESET_START: assert property (w01 && reg_wdata[4] |=> core_reset && dsp_hold_in_reset)
    else $error("full reset write did not start core reset");
  AST_CORE_RESET_SPAN: assert property ($rose(core_reset) |-> core_reset[*8] ##1 !core_reset)
    else $error("core reset span wrong");
  AST_RAM_CLEAR: assert property (coef_ram_clear == core_reset)
    else $error("ram clear not tied to core reset");
  AST_RESET_BITS_ZERO: assert property (reg_read && reg_addr == 8'h01 |-> ##2 reg_rdata[4:0] == 5'h00)
    else $error("reset request bits read back nonzero");
  AST_REG_RESET: assert property (w01 && reg_wdata[0] && !reg_wdata[4] |=> dsp_hold_in_reset && !mute_request
    && power_state == 2'h0 && switching_frequency_select == 3'h0 && !parallel_bridge_select
    && modulation_scheme_select == 2'h0 && !page_wrap_disable && !core_reset)
    else $error("register reset left a field set");
  AST_FREQ_576: assert property (switching_frequency_select == 3'h4 |=> switching_frequency_khz == 10'h240)
    else $error("576 kHz decode wrong");
  AST_FREQ_RESERVED: assert property (switching_frequency_select inside {3'h2, 3'h5, 3'h7}
    |=> freq_reserved && $stable(switching_frequency_khz))
    else $error("reserved frequency code mishandled");
  AST_FIELDS_WRITE: assert property (reg_write && reg_addr == 8'h02 && !core_reset
    |=> parallel_bridge_select == wdata_q[2] && modulation_scheme_select == wdata_q[1:0])
    else $error("output stage fields not written");
  AST_DSP_RUN: assert property (!dsp_hold_in_reset && !core_reset |=> dsp_running)
    else $error("dsp not running after release");
  AST_DSP_HELD: assert property (dsp_hold_in_reset || core_reset |=> !dsp_running)
    else $error("dsp running while held");
  AST_MUTE_NO_RISE: assert property (mute_request |=> volume_level <= $past(volume_level))
    else $error("volume rose while muted");
  AST_RAMP_STEP: assert property (!core_reset && !$past(core_reset) && $changed(volume_level)
    |-> (volume_level - $past(volume_level)) inside {8'h01, 8'hff})
    else $error("volume jumped by more than one code");
  AST_PLAY_DECODE: assert property (power_state == 2'h3 |=> state_play && !state_hiz)
    else $error("play state decode wrong");
  AST_WRAP_NEXT: assert property (wrap && !page_wrap_disable
    |=> next_page == $past(cur_page) + 8'h01 && next_addr == 8'h08)
    else $error("page end did not continue on next page");
  AST_WRAP_SAME: assert property (wrap && page_wrap_disable |=> next_page == $past(cur_page) && next_addr == 8'h00)
    else $error("page end did not wrap in same page");
endmodule // acr_core_regs_chk

bind acr_core_regs acr_core_regs_chk #(.CORE_RESET_CYCLES(CORE_RESET_CYCLES), .VOL_STEP_CYCLES(VOL_STEP_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .page_incr(page_incr), .cur_book(cur_book), .cur_page(cur_page), .cur_addr(cur_addr),
  .next_page(next_page), .next_addr(next_addr), .core_reset(core_reset), .coef_ram_clear(coef_ram_clear),
  .switching_frequency_select(switching_frequency_select), .switching_frequency_khz(switching_frequency_khz),
  .freq_reserved(freq_reserved), .parallel_bridge_select(parallel_bridge_select),
  .modulation_scheme_select(modulation_scheme_select), .dsp_hold_in_reset(dsp_hold_in_reset),
  .dsp_running(dsp_running), .mute_request(mute_request), .volume_level(volume_level),
  .power_state(power_state), .state_hiz(state_hiz), .state_play(state_play), .page_wrap_disable(page_wrap_disable));
`default_nettype wire

// ===== tb/acr_host.sv
// Purpose: Host on the control port, byte writes and reads.
// Assumes: Strobes launched at the falling edge, one cycle wide.
// Notes:   Released address and data lines show the inverse value.
`timescale 1ns/10ps
`default_nettype none

module acr_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_write,
  output var  logic       reg_read,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    // Stale values must not pass for live ones
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule // acr_host
`default_nettype wire

// ===== tb/acr_core_regs_tb.sv
// Purpose: Self-checking bench for the core control register group.
// Assumes: Volume step shortened to 2 cycles.
// Notes:   Host model drives the register port.
`timescale 1ns/10ps
`default_nettype none

module acr_core_regs_tb;
  logic clk, rst, reg_write, reg_read, page_incr, core_reset, coef_ram_clear, freq_reserved, parallel_bridge_select;
  logic dsp_hold_in_reset, dsp_running, mute_request, volume_ramping, state_deep_sleep, state_sleep, state_hiz;
  logic state_play, page_wrap_disable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cur_book, cur_page, cur_addr, next_page, next_addr, volume_level;
  logic [2:0] switching_frequency_select;
  logic [9:0] switching_frequency_khz, exp_khz;
  logic [1:0] modulation_scheme_select, power_state;
  logic [9:0] khz_tab [8] = '{10'h300, 10'h180, 10'h000, 10'h1e0, 10'h240, 10'h000, 10'h000, 10'h000};
  int         n_errors, check_count, i;

  acr_core_regs #(.VOL_STEP_CYCLES(2)) uut (.clk(clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .page_incr(page_incr), .cur_book(cur_book),
    .cur_page(cur_page), .cur_addr(cur_addr), .next_page(next_page), .next_addr(next_addr),
    .core_reset(core_reset), .coef_ram_clear(coef_ram_clear), .switching_frequency_select(switching_frequency_select),
    .switching_frequency_khz(switching_frequency_khz), .freq_reserved(freq_reserved),
    .parallel_bridge_select(parallel_bridge_select), .modulation_scheme_select(modulation_scheme_select),
    .dsp_hold_in_reset(dsp_hold_in_reset), .dsp_running(dsp_running), .mute_request(mute_request),
    .volume_level(volume_level), .volume_ramping(volume_ramping), .power_state(power_state),
    .state_deep_sleep(state_deep_sleep), .state_sleep(state_sleep), .state_hiz(state_hiz), .state_play(state_play),
    .page_wrap_disable(page_wrap_disable));

  acr_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  always #4 clk = ~clk;

  task chk(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk({2'b00, d}, {2'b00, e});
  endtask

  task pg(input logic [7:0] b, input logic [7:0] p, input logic [7:0] a, input logic [7:0] ep, input logic [7:0] ea);
    @(negedge clk);
    cur_book = b;
    cur_page = p;
    cur_addr = a;
    page_incr = 1'b1;
    @(negedge clk);
    page_incr = 1'b0;
    chk({2'b00, next_page}, {2'b00, ep});
    chk({2'b00, next_addr}, {2'b00, ea});
  endtask

  task test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    page_incr = 1'b0;
    {cur_book, cur_page, cur_addr} = 24'h00_0000;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rdchk(8'h01, 8'h00);
    rdchk(8'h02, 8'h00);
    rdchk(8'h03, 8'h10);
    rdchk(8'h0f, 8'h00);
    rdchk(8'h04, 8'h00);
    chk(state_deep_sleep, 1'b1);
    chk(dsp_running, 1'b0);
    exp_khz = 10'h300;
    for (i = 0; i < 8; i++) begin
      if (i != 6) begin
        u_host.wr(8'h02, {1'b0, i[2:0], 4'h0});
        @(negedge clk);
        if (!(i inside {2, 5, 7})) exp_khz = khz_tab[i];
        chk(freq_reserved, i inside {2, 5, 7});
        chk(switching_frequency_khz, exp_khz);
      end
    end
    for (i = 0; i < 3; i++) begin
      u_host.wr(8'h02, {5'h00, i[0], i[1:0]});
      chk(modulation_scheme_select, i[1:0]);
      chk(parallel_bridge_select, i[0]);
      rdchk(8'h02, {5'h00, i[0], i[1:0]});
    end
    for (i = 0; i < 4; i++) begin
      u_host.wr(8'h03, {6'h04, i[1:0]});
      @(negedge clk);
      chk({state_deep_sleep, state_sleep, state_hiz, state_play}, 4'b1000 >> i);
    end
    u_host.wr(8'h03, 8'h03);
    @(negedge clk);
    chk(dsp_running, 1'b1);
    repeat (600) @(negedge clk);
    chk(volume_level, 8'hff);
    u_host.wr(8'h03, 8'h0b);
    chk(mute_request, 1'b1);
    repeat (4) @(negedge clk);
    chk(volume_level > 8'hf0 && volume_level < 8'hff, 1'b1);
    repeat (600) @(negedge clk);
    chk(volume_level, 8'h00);
    chk(volume_ramping, 1'b0);
    u_host.wr(8'h03, 8'h03);
    repeat (4) @(negedge clk);
    chk(volume_level > 8'h00 && volume_level < 8'h10, 1'b1);
    u_host.wr(8'h02, 8'h46);
    u_host.wr(8'h0f, 8'h08);
    u_host.wr(8'h01, 8'h01);
    chk(coef_ram_clear, 1'b0);
    rdchk(8'h01, 8'h00);
    rdchk(8'h02, 8'h00);
    rdchk(8'h03, 8'h10);
    rdchk(8'h0f, 8'h00);
    u_host.wr(8'h02, 8'h46);
    u_host.wr(8'h03, 8'h03);
    u_host.wr(8'h01, 8'h10);
    chk(core_reset, 1'b1);
    chk(coef_ram_clear, 1'b1);
    u_host.wr(8'h02, 8'h05);
    repeat (10) @(negedge clk);
    chk(core_reset, 1'b0);
    chk(volume_level, 8'h00);
    rdchk(8'h02, 8'h00);
    rdchk(8'h03, 8'h10);
    rdchk(8'h01, 8'h00);
    pg(8'h01, 8'h05, 8'h7f, 8'h06, 8'h08);
    pg(8'h01, 8'h05, 8'h10, 8'h05, 8'h11);
    pg(8'h00, 8'h05, 8'h7f, 8'h05, 8'h80);
    u_host.wr(8'h0f, 8'h08);
    pg(8'h01, 8'h05, 8'h7f, 8'h05, 8'h00);
    rdchk(8'h0f, 8'h08);
    test_done;
  end

  initial begin
    #100000;
    n_errors++;
    test_done;
  end
endmodule // acr_core_regs_tb
`default_nettype wire
